// ===== verilog/dpram_consts.svh
`ifndef DPRAM_CONSTS_SVH
`define DPRAM_CONSTS_SVH

// storage geometry: 512 words of 32 data bits plus 4 parity bits
`define WORDS        512
`define WORD_W       36
`define DATA_W       32
`define PAR_W        4
`define PAR_LSB      32
`define ADDR_W       15
`define IDX_MSB      13
`define IDX_LSB      5
`define BLOCK_SEL    14
`define LANE_W       8

// width codes held in the configuration registers
`define WC_OFF       3'd0
`define WC_1         3'd1
`define WC_2         3'd2
`define WC_4         3'd3
`define WC_9         3'd4
`define WC_18        3'd5
`define WC_36        3'd6

// write modes
`define MODE_WF      2'd0
`define MODE_RF      2'd1
`define MODE_NC      2'd2

// cascade roles
`define ROLE_NONE    2'd0
`define ROLE_LOWER   2'd1
`define ROLE_UPPER   2'd2

// configuration register fields
`define CFG_W        12
`define CFG_RW       0
`define CFG_WW       3
`define CFG_MODE     6
`define CFG_STAGE    8
`define CFG_INV      9
`define CFG_ROLE     10
`define CFG_RST      12'h036
`define PRESET_RST   36'h000000000

// status register fields
`define ST_WR_ZERO   0
`define ST_RD_ZERO   1
`define ST_SEL       2

// register byte offsets
`define PADDR_W      8
`define OFF_CFG_A    8'h00
`define OFF_CFG_B    8'h04
`define OFF_PLO_A    8'h08
`define OFF_PHI_A    8'h0C
`define OFF_PLO_B    8'h10
`define OFF_PHI_B    8'h14
`define OFF_STATUS   8'h18

`endif

// ===== verilog/dpram_pkg.sv
`include "dpram_consts.svh"

package dpram_pkg;

   // whole state of the memory core
   typedef struct packed
   {
      logic [`WORDS-1:0][`WORD_W-1:0] mem;
      logic [1:0][`WORD_W-1:0]        latch;
      logic [1:0]                     hi_sel;
      logic [1:0][`CFG_W-1:0]         cfg;
      logic [1:0][`WORD_W-1:0]        preset;
      logic [`DATA_W-1:0]             prdata;
   } core_state_type;

   // output pipeline stage, one per port
   typedef struct packed
   {
      logic [`WORD_W-1:0] pipe;
   } stage_state_type;

endpackage

// ===== verilog/output_stage.sv
`timescale 1ns/1ps
`include "dpram_consts.svh"

module output_stage
   import dpram_pkg::*;
(
   input  wire logic               clk_sys,
   input  wire logic               sys_rst,
   input  wire logic               stage_select,
   input  wire logic               clock_invert,
   input  wire logic               stage_enable,
   input  wire logic [`WORD_W-1:0] latch_in,
   output logic      [`WORD_W-1:0] stage_out
);

   stage_state_type pos_r;
   stage_state_type pos_nxt;
   stage_state_type neg_r;
   stage_state_type neg_nxt;

   // both edges load only on the port's own enable
   always_comb
   begin
      pos_nxt = pos_r;
      neg_nxt = neg_r;
      if (stage_enable)
      begin
         pos_nxt.pipe = latch_in;
         neg_nxt.pipe = latch_in;
      end
   end

   // rising-edge copy: one extra cycle before data shows
   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
         pos_r <= '0;
      else
         pos_r <= pos_nxt;
   end

   // falling-edge copy for the inverted option; costs only half a cycle
   always_ff @(negedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
         neg_r <= '0;
      else
         neg_r <= neg_nxt;
   end

   // bypass when the stage is not selected
   always_comb
   begin
      if (!stage_select)
         stage_out = latch_in;
      else if (clock_invert)
         stage_out = neg_r.pipe;
      else
         stage_out = pos_r.pipe;
   end

endmodule

// ===== verilog/dual_port_block_ram.sv
// Operation
// - parity lanes stored as given, never computed
// - per-port optional output pipeline register
// - invert option clocks stage on other edge
// - stage loads only on own clock enable
// - widths 1, 2, 4, 9, 18, 36 per port
// - outputs 32+4 bits, valid low bits only
// - cascade pairs exactly one upper, one lower
// - cascaded read data comes from upper block
// - cascade uses all 15 bits, one-bit widths
// - 36-bit mode: four independent lane enables
// - 18-bit mode: lanes 0,2 and 1,3 paired
// - narrow modes: one enable drives all lanes
// - wide modes split byte data and parity
// - parity bits handled exactly like data bits
// - write-first shows written data same cycle
// - preset loads latch, memory untouched
// - inactive port holds memory and latch; stage still loads on its enable
// - pipeline stage adds one cycle latency, half a cycle when inverted
//
// Register access over APB and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "dpram_consts.svh"

module dual_port_block_ram
   import dpram_pkg::*;
(
   input  wire logic                clk_sys,
   input  wire logic                sys_rst,
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [`PADDR_W-1:0] paddr,
   input  wire logic [`DATA_W-1:0]  pwdata,
   output logic      [`DATA_W-1:0]  prdata,
   output logic                     pready,
   output logic                     pslverr,
   input  wire logic                port_a_active,
   input  wire logic [3:0]          byte_lane_write_a,
   input  wire logic [`ADDR_W-1:0]  port_address_a,
   input  wire logic [`DATA_W-1:0]  write_data_in_a,
   input  wire logic [`PAR_W-1:0]   parity_in_a,
   input  wire logic                output_preset_a,
   input  wire logic                output_stage_clock_enable_a,
   output logic      [`DATA_W-1:0]  read_data_out_a,
   output logic      [`PAR_W-1:0]   parity_out_a,
   input  wire logic                chain_in_a,
   output logic                     chain_out_a,
   input  wire logic                port_b_active,
   input  wire logic [3:0]          byte_lane_write_b,
   input  wire logic [`ADDR_W-1:0]  port_address_b,
   input  wire logic [`DATA_W-1:0]  write_data_in_b,
   input  wire logic [`PAR_W-1:0]   parity_in_b,
   input  wire logic                output_preset_b,
   input  wire logic                output_stage_clock_enable_b,
   output logic      [`DATA_W-1:0]  read_data_out_b,
   output logic      [`PAR_W-1:0]   parity_out_b,
   input  wire logic                chain_in_b,
   output logic                     chain_out_b
);

   core_state_type                 s_r;
   core_state_type                 s_nxt;
   logic [1:0]                     act;
   logic [1:0][3:0]                we;
   logic [1:0][`ADDR_W-1:0]        addr;
   logic [1:0][`WORD_W-1:0]        wdata;
   logic [1:0]                     preset_req;
   logic [1:0]                     stage_ce;
   logic [1:0]                     chain_in;
   logic [1:0][`WORD_W-1:0]        latch_eff;
   logic [1:0][`WORD_W-1:0]        port_out;
   logic                           mapped;
   logic                           wr_zero;
   logic                           rd_zero;

   // gather both ports into indexed form; parity rides above data
   assign act        = {port_b_active, port_a_active};
   assign we         = {byte_lane_write_b, byte_lane_write_a};
   assign addr       = {port_address_b, port_address_a};
   assign wdata[0]   = {parity_in_a, write_data_in_a};
   assign wdata[1]   = {parity_in_b, write_data_in_b};
   assign preset_req = {output_preset_b, output_preset_a};
   assign stage_ce   = {output_stage_clock_enable_b,
                        output_stage_clock_enable_a};
   assign chain_in   = {chain_in_b, chain_in_a};

   // place a 36-bit input at the word position chosen by width and address
   function automatic logic [`WORD_W-1:0] place
   (
      input logic [2:0]         wc,
      input logic [`IDX_MSB:0]  a,
      input logic [`WORD_W-1:0] v
   );
      logic [`WORD_W-1:0] r;
      r = '0;
      unique case (wc)
         `WC_1:  r = `WORD_W'(v[0]) << a[4:0];
         `WC_2:  r = `WORD_W'(v[1:0]) << {a[4:1], 1'b0};
         `WC_4:  r = `WORD_W'(v[3:0]) << {a[4:2], 2'b00};
         `WC_9:  r = (`WORD_W'(v[7:0]) << {a[4:3], 3'b000})
                   | (`WORD_W'(v[`PAR_LSB]) <<
                      (6'(`PAR_LSB) + 6'(a[4:3])));
         `WC_18: r = (`WORD_W'(v[15:0]) << {a[4], 4'b0000})
                   | (`WORD_W'(v[`PAR_LSB +: 2]) <<
                      (6'(`PAR_LSB) + 6'({a[4], 1'b0})));
         `WC_36: r = v;
         default: r = '0;
      endcase
      return r;
   endfunction

   // byte-lane enables expanded onto data bits and their parity bit
   function automatic logic [`WORD_W-1:0] lanes
   (
      input logic [2:0] wc,
      input logic [3:0] w
   );
      logic [3:0]         l;
      logic [`WORD_W-1:0] m;
      l = {4{w[0]}};
      m = '0;
      if (wc == `WC_36)
         l = w;
      else if (wc == `WC_18)
         l = {w[1], w[0], w[1], w[0]};
      for (int b = 0; b < 4; b++)
      begin
         m[b*`LANE_W +: `LANE_W] = {`LANE_W{l[b]}};
         m[`PAR_LSB + b]         = l[b];
      end
      return m;
   endfunction

   // pick the read width's slice; bits above it read as zero
   function automatic logic [`WORD_W-1:0] fmt
   (
      input logic [2:0]         wc,
      input logic [`IDX_MSB:0]  a,
      input logic [`WORD_W-1:0] w
   );
      logic [`WORD_W-1:0] r;
      r = '0;
      unique case (wc)
         `WC_1:  r = `WORD_W'(w[a[4:0]]);
         `WC_2:  r = `WORD_W'(w[{a[4:1], 1'b0} +: 2]);
         `WC_4:  r = `WORD_W'(w[{a[4:2], 2'b00} +: 4]);
         `WC_9:
         begin
            r[7:0]     = w[{a[4:3], 3'b000} +: 8];
            r[`PAR_LSB] = w[`PAR_LSB + a[4:3]];
         end
         `WC_18:
         begin
            r[15:0]           = w[{a[4], 4'b0000} +: 16];
            r[`PAR_LSB +: 2]  = w[`PAR_LSB + {a[4], 1'b0} +: 2];
         end
         `WC_36: r = w;
         default: r = '0;
      endcase
      return r;
   endfunction

   // ports and bus share one next-state process
   always_comb
   begin
      logic [2:0]               rw;
      logic [2:0]               ww;
      logic [1:0]               md;
      logic [1:0]               role;
      logic                     hit;
      logic [`IDX_MSB-`IDX_LSB:0] idx;
      logic [`WORD_W-1:0]       mask;
      logic [`WORD_W-1:0]       old_w;
      logic [`WORD_W-1:0]       new_w;
      rw    = '0;
      ww    = '0;
      md    = '0;
      role  = '0;
      hit   = 1'b0;
      idx   = '0;
      mask  = '0;
      old_w = '0;
      new_w = '0;
      s_nxt = s_r;
      // read data is registered in the setup phase, so answers need
      // no combinational path from the register file to prdata
      if (psel && !penable)
      begin
         unique case (paddr)
            `OFF_CFG_A:  s_nxt.prdata = `DATA_W'(s_r.cfg[0]);
            `OFF_CFG_B:  s_nxt.prdata = `DATA_W'(s_r.cfg[1]);
            `OFF_PLO_A:  s_nxt.prdata = s_r.preset[0][`DATA_W-1:0];
            `OFF_PHI_A:  s_nxt.prdata = `DATA_W'(s_r.preset[0][`PAR_LSB +:
                                                  `PAR_W]);
            `OFF_PLO_B:  s_nxt.prdata = s_r.preset[1][`DATA_W-1:0];
            `OFF_PHI_B:  s_nxt.prdata = `DATA_W'(s_r.preset[1][`PAR_LSB +:
                                                  `PAR_W]);
            `OFF_STATUS:
            begin
               s_nxt.prdata = '0;
               s_nxt.prdata[`ST_WR_ZERO]   = wr_zero;
               s_nxt.prdata[`ST_RD_ZERO]   = rd_zero;
               s_nxt.prdata[`ST_SEL +: 2] = s_r.hi_sel;
            end
            default: s_nxt.prdata = '0;
         endcase
      end
      // writes take effect in the access phase only
      if (psel && penable && pwrite)
      begin
         unique case (paddr)
            `OFF_CFG_A: s_nxt.cfg[0] = pwdata[`CFG_W-1:0];
            `OFF_CFG_B: s_nxt.cfg[1] = pwdata[`CFG_W-1:0];
            `OFF_PLO_A: s_nxt.preset[0][`DATA_W-1:0] = pwdata;
            `OFF_PHI_A: s_nxt.preset[0][`PAR_LSB +: `PAR_W] =
                           pwdata[`PAR_W-1:0];
            `OFF_PLO_B: s_nxt.preset[1][`DATA_W-1:0] = pwdata;
            `OFF_PHI_B: s_nxt.preset[1][`PAR_LSB +: `PAR_W] =
                           pwdata[`PAR_W-1:0];
            default: ;
         endcase
      end
      // port A first, then B: on the same word B's bits land last,
      // while read-first and plain reads see the contents from before this edge
      for (int p = 0; p < 2; p++)
      begin
         rw   = s_r.cfg[p][`CFG_RW +: 3];
         ww   = s_r.cfg[p][`CFG_WW +: 3];
         md   = s_r.cfg[p][`CFG_MODE +: 2];
         role = s_r.cfg[p][`CFG_ROLE +: 2];
         // bit 14 only steers the cascaded pair
         hit  = (role == `ROLE_NONE)
              || (addr[p][`BLOCK_SEL] == (role == `ROLE_UPPER));
         idx  = addr[p][`IDX_MSB:`IDX_LSB];
         if (act[p])
         begin
            if (preset_req[p])
            begin
               s_nxt.latch[p]  = s_r.preset[p];
               s_nxt.hi_sel[p] = 1'b1;
            end
            else
            begin
               old_w = s_nxt.mem[idx];
               s_nxt.hi_sel[p] = addr[p][`BLOCK_SEL];
               // narrow modes listen to one enable bit only, so a stray
               // upper bit must not turn a read into a masked write
               if (hit && (ww != `WC_OFF) && (|lanes(ww, we[p])))
               begin
                  mask  = place(ww, addr[p][`IDX_MSB:0], {`WORD_W{1'b1}})
                        & lanes(ww, we[p]);
                  new_w = (old_w & ~mask)
                        | (place(ww, addr[p][`IDX_MSB:0], wdata[p])
                           & mask);
                  s_nxt.mem[idx] = new_w;
                  unique case (md)
                     `MODE_WF: s_nxt.latch[p] =
                                  fmt(rw, addr[p][`IDX_MSB:0], new_w);
                     `MODE_RF: s_nxt.latch[p] =
                                  fmt(rw, addr[p][`IDX_MSB:0],
                                      s_r.mem[idx]);
                     `MODE_NC: s_nxt.latch[p] = s_r.latch[p];
                     default:  s_nxt.latch[p] = s_r.latch[p];
                  endcase
               end
               else
               begin
                  s_nxt.latch[p] = fmt(rw, addr[p][`IDX_MSB:0],
                                       s_r.mem[idx]);
               end
            end
         end
      end
   end

   // one register for all core state; configuration comes up at CFG_RST, everything else zero
   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         s_r        <= '0;
         s_r.cfg    <= {2{`CFG_RST}};
         s_r.preset <= {2{`PRESET_RST}};
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   // status flags for configurations that leave a side without width
   assign wr_zero = (s_r.cfg[0][`CFG_WW +: 3] == `WC_OFF)
                 && (s_r.cfg[1][`CFG_WW +: 3] == `WC_OFF);
   assign rd_zero = (s_r.cfg[0][`CFG_RW +: 3] == `WC_OFF)
                 && (s_r.cfg[1][`CFG_RW +: 3] == `WC_OFF);

   // zero-wait slave: read data was captured in the setup phase
   assign mapped  = (paddr == `OFF_CFG_A) || (paddr == `OFF_CFG_B)
                 || (paddr == `OFF_PLO_A) || (paddr == `OFF_PHI_A)
                 || (paddr == `OFF_PLO_B) || (paddr == `OFF_PHI_B)
                 || (paddr == `OFF_STATUS);
   assign pready  = psel && penable;
   assign pslverr = psel && penable && !mapped;
   assign prdata  = s_r.prdata;

   // per-port output path: the upper block of a pair takes bit 0 from
   // the chain when the last access addressed the lower half
   for (genvar p = 0; p < 2; p++)
   begin : g_port
      always_comb
      begin
         latch_eff[p] = s_r.latch[p];
         if ((s_r.cfg[p][`CFG_ROLE +: 2] == `ROLE_UPPER)
             && !s_r.hi_sel[p])
            latch_eff[p][0] = chain_in[p];
      end

      output_stage u_stage
      (
         .clk_sys      (clk_sys),
         .sys_rst      (sys_rst),
         .stage_select (s_r.cfg[p][`CFG_STAGE]),
         .clock_invert (s_r.cfg[p][`CFG_INV]),
         .stage_enable (stage_ce[p]),
         .latch_in     (latch_eff[p]),
         .stage_out    (port_out[p])
      );
   end

   // lower block hands its own bit 0 up the chain
   assign chain_out_a     = s_r.latch[0][0];
   assign chain_out_b     = s_r.latch[1][0];
   assign read_data_out_a = port_out[0][`DATA_W-1:0];
   assign parity_out_a    = port_out[0][`PAR_LSB +: `PAR_W];
   assign read_data_out_b = port_out[1][`DATA_W-1:0];
   assign parity_out_b    = port_out[1][`PAR_LSB +: `PAR_W];

endmodule

// ===== tb/dpram_checker.sv
`timescale 1ns/1ps
`include "dpram_consts.svh"

module dpram_checker
(
   input wire logic                clk_sys,
   input wire logic                sys_rst,
   input wire logic                psel,
   input wire logic                penable,
   input wire logic                pwrite,
   input wire logic [`PADDR_W-1:0] paddr,
   input wire logic [`DATA_W-1:0]  prdata,
   input wire logic                pready,
   input wire logic                pslverr,
   input wire logic                port_a_active,
   input wire logic                output_stage_clock_enable_a,
   input wire logic [`DATA_W-1:0]  read_data_out_a,
   input wire logic [`PAR_W-1:0]   parity_out_a,
   input wire logic                chain_out_a,
   input wire logic                port_b_active,
   input wire logic                output_stage_clock_enable_b,
   input wire logic [`DATA_W-1:0]  read_data_out_b,
   input wire logic [`PAR_W-1:0]   parity_out_b
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);

   // a port is quiet when idle, stage not loading and no config write
   sequence quiet_a;
      !port_a_active && !output_stage_clock_enable_a && !psel
      ##1 !output_stage_clock_enable_a;
   endsequence
   sequence quiet_b;
      !port_b_active && !output_stage_clock_enable_b && !psel
      ##1 !output_stage_clock_enable_b;
   endsequence
   sequence setup_phase;
      psel && !penable;
   endsequence

   a_hold_port_a:
      assert property (quiet_a |-> $stable({parity_out_a, read_data_out_a}))
      else $error("port a output moved while idle");
   a_hold_port_b:
      assert property (quiet_b |-> $stable({parity_out_b, read_data_out_b}))
      else $error("port b output moved while idle");
   a_chain_hold:
      assert property (!port_a_active |=> $stable(chain_out_a))
      else $error("chain output moved while idle");
   a_ready_access:
      assert property (psel && penable |-> pready)
      else $error("no ready in access cycle");
   a_ready_idle:
      assert property (!(psel && penable) |-> !pready)
      else $error("ready outside access cycle");
   a_err_unmapped:
      assert property (psel && penable && paddr > 8'h18 |-> pslverr)
      else $error("unmapped access without error");
   a_err_mapped:
      assert property (psel && penable && paddr <= 8'h18
                       && paddr[1:0] == 2'h0 |-> !pslverr)
      else $error("error on mapped access");
   a_prdata_stands:
      assert property (!(psel && !penable) |=> $stable(prdata))
      else $error("read data moved outside setup");
   a_unmapped_zero:
      assert property (setup_phase and (!pwrite && paddr > 8'h18)
                       |=> prdata == 32'h00000000)
      else $error("unmapped read not zero");
endmodule

bind dual_port_block_ram dpram_checker dpram_checker_i
(
   .clk_sys, .sys_rst, .psel, .penable, .pwrite, .paddr, .prdata,
   .pready, .pslverr, .port_a_active, .output_stage_clock_enable_a,
   .read_data_out_a, .parity_out_a, .chain_out_a, .port_b_active,
   .output_stage_clock_enable_b, .read_data_out_b, .parity_out_b
);

// ===== tb/port_user.sv
`timescale 1ns/1ps

// fabric logic on one memory port
module port_user
(
   input  wire logic        clk_sys,
   output logic             active,
   output logic [3:0]       lane_we,
   output logic [14:0]      address,
   output logic [31:0]      data,
   output logic [3:0]       parity,
   output logic             preset,
   output logic             stage_ce
);
   int          wbits = 36;
   logic [31:0] dmask;
   logic [3:0]  pmask;

   // unused upper lanes must arrive as zeros
   always_comb
   begin
      dmask = (wbits >= 32) ? 32'hFFFFFFFF : (wbits == 18) ? 32'h0000FFFF :
              (wbits == 9) ? 32'h000000FF : (32'h1 << wbits) - 32'h1;
      pmask = (wbits == 36) ? 4'hF : (wbits == 18) ? 4'h3 :
              (wbits == 9) ? 4'h1 : 4'h0;
   end

   initial
   begin
      {active, lane_we, address, data, parity, preset, stage_ce} = '0;
   end

   // one access, held for one rising edge; address and stage enable stay as driven afterwards
   task automatic op(input logic act, input logic [3:0] we,
                     input logic [14:0] a, input logic [35:0] v,
                     input logic pre, input logic ce);
      @(posedge clk_sys);
      active <= act;
      lane_we <= we;
      address <= {1'b0, a[13:0]};
      data <= v[31:0] & dmask;
      parity <= v[35:32] & pmask;
      preset <= pre;
      stage_ce <= ce;
      @(posedge clk_sys);
      active <= 1'b0;
      lane_we <= 4'h0;
      preset <= 1'b0;
      // released lines must not look like the last value
      data <= ~data;
      parity <= ~parity;
   endtask
endmodule

// ===== tb/dual_port_block_ram_tb_top.sv
`timescale 1ns/1ps
`include "dpram_consts.svh"

module dual_port_block_ram_tb_top
   import dpram_pkg::*;
;
   logic clk_sys = 1'b0;
   logic sys_rst = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h00000000, prdata, read_data_out_a;
   logic [31:0] write_data_in_a, write_data_in_b, read_data_out_b, r;
   logic [3:0] byte_lane_write_a, parity_in_a, parity_out_a;
   logic [3:0] byte_lane_write_b, parity_in_b, parity_out_b;
   logic [14:0] port_address_a, port_address_b;
   logic pready, pslverr, port_a_active, port_b_active, e;
   logic output_preset_a, output_stage_clock_enable_a, chain_out_a;
   logic output_preset_b, output_stage_clock_enable_b, chain_out_b;
   logic [35:0] v;
   int fail_count = 0;
   int num_checks = 0;
   wire logic [35:0] qa = {parity_out_a, read_data_out_a};
   wire logic [35:0] qb = {parity_out_b, read_data_out_b};

   always #50 clk_sys = ~clk_sys;

   dual_port_block_ram dual_port_block_ram_i
   (
      .clk_sys, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .port_a_active, .byte_lane_write_a,
      .port_address_a, .write_data_in_a, .parity_in_a, .output_preset_a,
      .output_stage_clock_enable_a, .read_data_out_a, .parity_out_a,
      .chain_in_a(1'b0), .chain_out_a, .port_b_active,
      .byte_lane_write_b, .port_address_b, .write_data_in_b, .parity_in_b,
      .output_preset_b, .output_stage_clock_enable_b, .read_data_out_b,
      .parity_out_b, .chain_in_b(1'b0), .chain_out_b
   );

   port_user pa (.clk_sys, .active(port_a_active),
      .lane_we(byte_lane_write_a), .address(port_address_a),
      .data(write_data_in_a), .parity(parity_in_a),
      .preset(output_preset_a), .stage_ce(output_stage_clock_enable_a));
   port_user pb (.clk_sys, .active(port_b_active),
      .lane_we(byte_lane_write_b), .address(port_address_b),
      .data(write_data_in_b), .parity(parity_in_b),
      .preset(output_preset_b), .stage_ce(output_stage_clock_enable_b));

   task automatic chk(input logic [35:0] got, input logic [35:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         fail_count++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // apb transfer; ends at the edge where pready was seen
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      @(posedge clk_sys);
      while (pready !== 1'b1)
         @(posedge clk_sys);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // inverted stage loads on the falling edge, so look just after it
   task automatic settle;
      @(negedge clk_sys);
      #1;
   endtask

   task automatic rb(input logic [14:0] a, input logic [35:0] x);
      pb.op(1'b1, 4'h0, a, 36'h000000000, 1'b0, 1'b0);
      settle;
      chk(qb, x);
   endtask

   task automatic print_verdict;
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   initial
   begin
      #(100 * 3000);
      fail_count++;
      $display("ERROR %0t: watchdog expired", $time);
      print_verdict;
   end

   initial
   begin
      repeat (8) @(posedge clk_sys);
      sys_rst <= 1'b0;
      apb(1'b0, `OFF_CFG_A, 32'h00000000);
      chk({4'h0, r}, {24'h000000, `CFG_RST});
      apb(1'b0, 8'h1C, 32'h00000000);
      chk({3'h0, e, r}, 36'h100000000);
      apb(1'b1, 8'h1C, 32'hFFFFFFFF);
      chk({35'h0, e}, 36'h000000001);
      $display("test registers done");
      pa.op(1'b1, 4'hF, 15'h0060, 36'h9A5A51234, 1'b0, 1'b0);
      settle;
      chk(qa, 36'h9A5A51234);
      rb(15'h0060, 36'h9A5A51234);
      pa.op(1'b1, 4'h5, 15'h0060, 36'h6FFFFFFFF, 1'b0, 1'b0);
      rb(15'h0060, 36'hCA5FF12FF);
      chk({35'h0, chain_out_b}, 36'h000000001);
      v = qa;
      pa.op(1'b0, 4'hF, 15'h0060, 36'h000000000, 1'b1, 1'b0);
      settle;
      chk(qa, v);
      rb(15'h0060, 36'hCA5FF12FF);
      $display("test lanes done");
      apb(1'b1, `OFF_CFG_A, 32'h00000026);
      pa.wbits = 9;
      pa.op(1'b1, 4'hE, 15'h0068, 36'h100000077, 1'b0, 1'b0);
      rb(15'h0060, 36'hCA5FF12FF);
      pa.op(1'b1, 4'h1, 15'h0068, 36'h100000077, 1'b0, 1'b0);
      rb(15'h0060, 36'hEA5FF77FF);
      apb(1'b1, `OFF_CFG_A, 32'h0000002E);
      pa.wbits = 18;
      pa.op(1'b1, 4'h1, 15'h0060, 36'h30000BEEF, 1'b0, 1'b0);
      rb(15'h0060, 36'hFA5FF77EF);
      $display("test widths done");
      apb(1'b1, `OFF_CFG_A, 32'h00000076);
      pa.wbits = 36;
      pa.op(1'b1, 4'hF, 15'h0060, 36'h111111111, 1'b0, 1'b0);
      settle;
      chk(qa, 36'hFA5FF77EF);
      apb(1'b1, `OFF_CFG_A, 32'h000000B6);
      pa.op(1'b1, 4'hF, 15'h0060, 36'h222222222, 1'b0, 1'b0);
      settle;
      chk(qa, 36'hFA5FF77EF);
      rb(15'h0060, 36'h222222222);
      apb(1'b1, `OFF_PLO_A, 32'hCAFE0001);
      apb(1'b1, `OFF_PHI_A, 32'h00000005);
      apb(1'b1, `OFF_CFG_A, 32'h00000036);
      pa.op(1'b1, 4'hF, 15'h0060, 36'h000000000, 1'b1, 1'b0);
      settle;
      chk(qa, 36'h5CAFE0001);
      rb(15'h0060, 36'h222222222);
      $display("test modes done");
      apb(1'b1, `OFF_CFG_A, 32'h00000136);
      pa.op(1'b1, 4'h0, 15'h0060, 36'h000000000, 1'b0, 1'b1);
      settle;
      chk(qa, 36'h5CAFE0001);
      settle;
      chk(qa, 36'h222222222);
      pa.op(1'b1, 4'h0, 15'h0000, 36'h000000000, 1'b0, 1'b0);
      settle;
      settle;
      chk(qa, 36'h222222222);
      pa.op(1'b1, 4'h0, 15'h0060, 36'h000000000, 1'b0, 1'b0);
      apb(1'b1, `OFF_CFG_A, 32'h00000336);
      pa.op(1'b1, 4'h0, 15'h0000, 36'h000000000, 1'b0, 1'b1);
      settle;
      chk(qa, 36'h000000000);
      $display("test stage done");
      apb(1'b1, `OFF_CFG_A, 32'h00000809);
      pa.op(1'b1, 4'h1, 15'h0061, 36'h000000000, 1'b0, 1'b0);
      settle;
      chk(qa, 36'h000000000);
      chk({35'h0, chain_out_a}, 36'h000000001);
      rb(15'h0060, 36'h222222222);
      $display("test cascade done");
      print_verdict;
   end
endmodule
